// ===== fram_two_wire_slave.v
`timescale 1ns/1ps
// Contract
// - Rising data with clock high is a stop; abort pending operation.
// - Falling data with clock high is a start; abort, expect slave address.
// - Receiver acks ninth bit low; no ack aborts to idle, waiting for a new start.
// - First byte is slave address; top nibble must match type code.
// - Address bits three to one select page, top three address bits.
// - Address bit zero is direction: one read, zero write.
// - Write: byte after address is low address, latched with page.
// - Read has no word address; page from slave byte, low bits latched.
// - Address increments after each data byte, before ack; wraps to zero.
// - No limit on consecutive bytes in one transaction.
// - Every byte shifts most significant bit first.
// - Byte committed after eighth bit before ack; early abort writes nothing.
// - No write busy time; new addressing acked immediately.
// - Protect high: no write, no data ack, no address increment.
// - After read address ack, drive byte at current address next clock.
// - Master ack sends next byte; no ack ends read, releases data.
// - Data sampled on rising serial clock, changed on falling.
// - Device is slave only; never drives clock, start or stop.
module fram_two_wire_slave #(
	parameter DEPTH = 2048
) (
	input  wire       clock,
	input  wire       sys_rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire       wp_in
);

`include "fram_slave_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Pin sampling: three flops, change taken once second and third agree
reg  [2:0]              scl_sync;
reg  [2:0]              sda_sync;
reg  [2:0]              wp_sync;
reg                     scl;
reg                     sda;
reg                     wp;

// Clock pin
always @(posedge clock) begin
	if (sys_rst) begin
		scl_sync <= 3'h7;
		scl      <= 1'b1;
	end else begin
		scl_sync <= {scl_sync[1:0], scl_in};
		if (scl_sync[1] == scl_sync[2])
			scl <= scl_sync[2];
	end
end

// Data pin, resets to the pulled-up idle level so no false start follows reset
always @(posedge clock) begin
	if (sys_rst) begin
		sda_sync <= 3'h7;
		sda      <= 1'b1;
	end else begin
		sda_sync <= {sda_sync[1:0], sda_in};
		if (sda_sync[1] == sda_sync[2])
			sda <= sda_sync[2];
	end
end

// Protect pin
always @(posedge clock) begin
	if (sys_rst) begin
		wp_sync <= 3'h0;
		wp      <= 1'b0;
	end else begin
		wp_sync <= {wp_sync[1:0], wp_in};
		if (wp_sync[1] == wp_sync[2])
			wp <= wp_sync[2];
	end
end

// Edge and condition detection on the filtered levels
reg                     scl_d;
reg                     sda_d;

always @(posedge clock) begin
	if (sys_rst) begin
		scl_d <= 1'b1;
		sda_d <= 1'b1;
	end else begin
		scl_d <= scl;
		sda_d <= sda;
	end
end

wire scl_rise   = scl & ~scl_d;
wire scl_fall   = ~scl & scl_d;
wire start_seen = scl & scl_d & sda_d & ~sda;
wire stop_seen  = scl & scl_d & ~sda_d & sda;

////////////////////////////////////////////////////////////////////////////////
// Array and state
reg  [7:0]              mem [0:DEPTH-1];
reg  [2:0]              state;
reg  [2:0]              bit_cnt;
reg  [7:0]              shift;
reg  [`ADDR_W-1:0]      addr;
reg                     is_read;
reg                     ack_good;
reg                     ack_phase;
reg                     drive_low;
reg                     after_ack;

// Next values, worked out in one combinational process
reg  [2:0]              next_state;
reg  [2:0]              next_bit_cnt;
reg  [7:0]              next_shift;
reg  [`ADDR_W-1:0]      next_addr;
reg                     next_is_read;
reg                     next_ack_good;
reg                     next_ack_phase;
reg                     next_drive_low;
reg                     next_after_ack;
reg                     mem_we;
wire [7:0]              mem_rd = mem[addr];

////////////////////////////////////////////////////////////////////////////////
// Helpers
function [`ADDR_W-1:0] step_addr;
	input [`ADDR_W-1:0] a;
	begin
		step_addr = a + `ADDR_STEP; // natural wrap past the top
	end
endfunction

// Type nibble check, shared by the ack and the address latch
function type_match;
	input [7:0] b;
	begin
		type_match = (b[`SA_TYPE_HI:`SA_TYPE_LO] == `DEV_TYPE_CODE);
	end
endfunction

// Slave only: the clock is never driven, data only pulled low
assign sda_out = 1'b0;
assign sda_oe  = drive_low;

////////////////////////////////////////////////////////////////////////////////
// Next-state logic
always @* begin
	next_state     = state;
	next_bit_cnt   = bit_cnt;
	next_shift     = shift;
	next_addr      = addr;
	next_is_read   = is_read;
	next_ack_good  = ack_good;
	next_ack_phase = ack_phase;
	next_drive_low = drive_low;
	next_after_ack = after_ack;
	mem_we         = 1'b0;

	if (start_seen) begin
		// Abort and wait for a new address; a cut byte is never written
		next_state     = `ST_ADDR;
		next_bit_cnt   = `BIT_FIRST;
		next_drive_low = 1'b0;
		next_ack_phase = 1'b0;
		next_after_ack = 1'b0;
	end else if (stop_seen) begin
		next_state     = `ST_IDLE;
		next_drive_low = 1'b0;
		next_ack_phase = 1'b0;
		next_after_ack = 1'b0;
	end else begin
		case (state)
		`ST_IDLE: begin
			next_drive_low = 1'b0;
		end
		`ST_ADDR, `ST_WORD, `ST_WDATA: begin
			if (ack_phase) begin
				// Hold ack through ninth high, release on its falling edge
				if (scl_fall) begin
					next_drive_low = 1'b0;
					next_ack_phase = 1'b0;
					next_bit_cnt   = `BIT_FIRST;
					if (!ack_good)
						next_state = `ST_IDLE;
					else if (state == `ST_ADDR && is_read) begin
						next_state     = `ST_RDATA;
						next_shift     = mem_rd;
						next_drive_low = ~mem_rd[7];
					end else if (state == `ST_ADDR)
						next_state = `ST_WORD;
					else
						next_state = `ST_WDATA;
				end
			end else if (scl_rise) begin
				next_shift     = {shift[6:0], sda};
				next_bit_cnt   = bit_cnt - 3'h1;
				next_after_ack = (bit_cnt == 3'h0);
			end else if (scl_fall && after_ack) begin
				// Eighth bit done: decide, commit and ack in the same low phase
				next_after_ack = 1'b0;
				next_ack_phase = 1'b1;
				case (state)
				`ST_ADDR: begin
					next_ack_good  = type_match(shift);
					next_drive_low = type_match(shift);
					next_is_read   = (shift[`SA_DIR_BIT] == `DIR_READ);
					if (type_match(shift))
						next_addr = {shift[`SA_PAGE_HI:`SA_PAGE_LO], addr[`LOW_W-1:0]};
				end
				`ST_WORD: begin
					next_ack_good  = 1'b1;
					next_drive_low = 1'b1;
					next_addr      = {addr[`ADDR_W-1:`LOW_W], shift};
				end
				`ST_WDATA: begin
					next_ack_good  = ~wp;
					next_drive_low = ~wp;
					if (!wp) begin
						mem_we    = 1'b1;
						next_addr = step_addr(addr);
					end
				end
				default: begin
					next_ack_good  = 1'b0;
					next_drive_low = 1'b0;
				end
				endcase
			end
		end
		`ST_RDATA: begin
			if (scl_fall) begin
				if (after_ack) begin
					// Byte out: let go for the master's ack and step the address
					next_drive_low = 1'b0;
					next_after_ack = 1'b0;
					next_addr      = step_addr(addr);
					next_state     = `ST_ACK_IN;
				end else begin
					next_drive_low = ~shift[6];
					next_shift     = {shift[6:0], 1'b0};
				end
			end else if (scl_rise) begin
				next_bit_cnt   = bit_cnt - 3'h1;
				next_after_ack = (bit_cnt == 3'h0);
			end
		end
		`ST_ACK_IN: begin
			if (scl_rise)
				next_ack_good = ~sda;
			else if (scl_fall) begin
				next_bit_cnt = `BIT_FIRST;
				if (ack_good) begin
					next_state     = `ST_RDATA;
					next_shift     = mem_rd;
					next_drive_low = ~mem_rd[7];
				end else
					next_state = `ST_IDLE;
			end
		end
		default: next_state = `ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registers, one process each
always @(posedge clock) begin
	if (sys_rst)
		state <= `ST_IDLE;
	else
		state <= next_state;
end

always @(posedge clock) begin
	if (sys_rst)
		bit_cnt <= `BIT_FIRST;
	else
		bit_cnt <= next_bit_cnt;
end

always @(posedge clock) begin
	if (sys_rst)
		shift <= `BYTE_RESET;
	else
		shift <= next_shift;
end

always @(posedge clock) begin
	if (sys_rst)
		addr <= `ADDR_RESET;
	else
		addr <= next_addr;
end

always @(posedge clock) begin
	if (sys_rst)
		is_read <= 1'b0;
	else
		is_read <= next_is_read;
end

always @(posedge clock) begin
	if (sys_rst)
		ack_good <= 1'b0;
	else
		ack_good <= next_ack_good;
end

always @(posedge clock) begin
	if (sys_rst)
		ack_phase <= 1'b0;
	else
		ack_phase <= next_ack_phase;
end

always @(posedge clock) begin
	if (sys_rst)
		drive_low <= 1'b0;
	else
		drive_low <= next_drive_low;
end

always @(posedge clock) begin
	if (sys_rst)
		after_ack <= 1'b0;
	else
		after_ack <= next_after_ack;
end

// Array write kept apart so no reset branch ever touches the memory
always @(posedge clock) begin
	if (!sys_rst && mem_we)
		mem[addr] <= shift;
end

endmodule // fram_two_wire_slave

// ===== fram_slave_map.vh
`ifndef FRAM_SLAVE_MAP_VH
`define FRAM_SLAVE_MAP_VH

// Slave address byte layout
`define SA_TYPE_HI       7
`define SA_TYPE_LO       4
`define SA_PAGE_HI       3
`define SA_PAGE_LO       1
`define SA_DIR_BIT       0
`define DIR_READ         1'b1

// Device-type code, value arbitrary
`define DEV_TYPE_CODE    4'h5

// Address and byte sizing
`define ADDR_W           11
`define LOW_W            8
`define PAGE_W           3
`define BIT_LAST         3'h7
`define BIT_FIRST        3'h7
`define ADDR_STEP        11'h001
`define ADDR_RESET       11'h000
`define BYTE_RESET       8'h00

// Bus state codes
`define ST_IDLE          3'h0
`define ST_ADDR          3'h1
`define ST_WORD          3'h2
`define ST_WDATA         3'h3
`define ST_RDATA         3'h4
`define ST_ACK_OUT       3'h5
`define ST_ACK_IN        3'h6

`endif

// ===== fram_slave_chk.sv
`timescale 1ns/1ps
`include "fram_slave_map.vh"
module fram_slave_chk (
	input wire clock,
	input wire sys_rst,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire wp_in
);
	reg [4:0] n;
	reg [7:0] sh;
	reg       p_scl;
	reg       p_sda;
	wire      st = scl_in & p_scl & p_sda & ~sda_in;
	wire      sp = scl_in & p_scl & ~p_sda & sda_in;
	// Bit count since the last start, saturating, so only the first byte is judged
	always @(posedge clock) begin
		p_scl <= scl_in;
		p_sda <= sda_in;
		if (sys_rst || st)
			n <= 5'h00;
		else if (scl_in && !p_scl && n != 5'h1f) begin
			n <= n + 5'h01;
			sh <= {sh[6:0], sda_in};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_open_drain: assert property (sda_oe |-> !sda_out)
		else $error("data driven high");
	a_stop_quiet: assert property (sp |=> !sda_oe [*8])
		else $error("drive after stop");
	a_start_quiet: assert property (st |=> !sda_oe [*8])
		else $error("drive after start");
	a_edge_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 3))
		else $error("data changed near clock high");
	a_hold_high: assert property (scl_in && p_scl && sda_oe |=> sda_oe)
		else $error("data dropped while clock high");
	a_release_low: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("release while clock high");
	a_type_gate: assert property (n == 5'h08 && sh[7:4] != `DEV_TYPE_CODE |-> !sda_oe)
		else $error("ack for foreign type");
	a_type_ack: assert property (n == 5'h08 && sh[7:4] == `DEV_TYPE_CODE && scl_in && !p_scl
		|-> sda_oe)
		else $error("no ack for own type");
	c_start: cover property (st);
	c_stop: cover property (sp);
	c_ack: cover property (n == 5'h08 && sda_oe);
endmodule // fram_slave_chk
bind fram_two_wire_slave fram_slave_chk chk (.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in));

// ===== two_wire_master.sv
`timescale 1ns/1ps
module two_wire_master (
	input  wire clock,
	input  wire sda_line,
	output reg  scl,
	output reg  sda_m
);
	initial begin
		scl = 1'h1;
		sda_m = 1'h1;
	end
	task tick(input integer k);
		repeat (k) @(posedge clock);
	endtask
	// Data moves 5 cycles into low so it never races the clock fall
	task start;
		tick(5); sda_m <= 1'h1; tick(10); scl <= 1'h1; tick(10); sda_m <= 1'h0; tick(10); scl <= 1'h0;
	endtask
	task stop;
		tick(5); sda_m <= 1'h0; tick(15); scl <= 1'h1; tick(10); sda_m <= 1'h1; tick(10);
	endtask
	task bitw(input b);
		tick(5); sda_m <= b; tick(15); scl <= 1'h1; tick(20); scl <= 1'h0;
	endtask
	task bitr(output b);
		tick(5); sda_m <= 1'h1; tick(15); scl <= 1'h1; tick(19); b = sda_line; tick(1); scl <= 1'h0;
	endtask
	task wbyte(input [7:0] d, output ack);
		integer i;
		for (i = 7; i >= 0; i = i - 1) bitw(d[i]);
		bitr(ack);
	endtask
	task rbyte(input ack, output [7:0] d);
		integer i;
		for (i = 7; i >= 0; i = i - 1) bitr(d[i]);
		bitw(ack);
	endtask
endmodule // two_wire_master

// ===== serial_fram_two_wire_slave_tb.sv
`timescale 1ns/1ps
`include "fram_slave_map.vh"
module serial_fram_two_wire_slave_tb;
	reg        clock;
	reg        sys_rst;
	reg        wp_in;
	reg        ack;
	reg  [7:0] d;
	wire       scl, sda_m, sda_out, sda_oe;
	wire       sda_line = sda_m & ~sda_oe;
	integer    err_count = 0, samples_checked = 0, cyc = 0;
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	two_wire_master m (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
	fram_two_wire_slave #(.DEPTH(2048)) dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input [7:0] got, input [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			err_count = err_count + 1;
			final_report;
		end
	end
	task wsend(input [7:0] b, input e);
		m.wbyte(b, ack);
		chk({7'h00, ack}, {7'h00, e});
	endtask
	task rget(input [7:0] e, input last);
		m.rbyte(last, d);
		chk(d, e);
	endtask
	task seek(input [2:0] pg, input [7:0] lo);
		m.start;
		wsend({`DEV_TYPE_CODE, pg, 1'h0}, 1'h0);
		wsend(lo, 1'h0);
	endtask
	task rd_open(input [2:0] pg);
		m.start;
		wsend({`DEV_TYPE_CODE, pg, 1'h1}, 1'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_wrap_write;
		seek(3'h7, 8'hff);
		wsend(8'h11, 1'h0);
		wsend(8'h22, 1'h0);
		wsend(8'h33, 1'h0);
		m.stop;
	endtask
	task t_random_read;
		seek(3'h7, 8'hff);
		rd_open(3'h7);
		rget(8'h11, 1'h0);
		rget(8'h22, 1'h0);
		rget(8'h33, 1'h1);
		m.stop;
	endtask
	task t_current_read;
		seek(3'h7, 8'hff);
		rd_open(3'h7);
		rget(8'h11, 1'h1);
		m.stop;
		rd_open(3'h0);
		rget(8'h22, 1'h1);
		m.stop;
	endtask
	// Two partial bytes, one cut by stop and one by start, must leave 5a in place
	task t_abort;
		seek(3'h1, 8'h10);
		wsend(8'h5a, 1'h0);
		seek(3'h1, 8'h10);
		repeat (4) m.bitw(1'h0);
		m.stop;
		seek(3'h1, 8'h10);
		repeat (4) m.bitw(1'h0);
		rd_open(3'h1);
		rget(8'h5a, 1'h1);
		m.stop;
	endtask
	task t_mismatch;
		m.start;
		wsend({~`DEV_TYPE_CODE, 3'h0, 1'h1}, 1'h1);
		m.stop;
	endtask
	task t_protect;
		wp_in <= 1'h1;
		seek(3'h1, 8'h10);
		wsend(8'h77, 1'h1);
		m.stop;
		wp_in <= 1'h0;
		rd_open(3'h1);
		rget(8'h5a, 1'h1);
		m.stop;
	endtask
	initial begin
		sys_rst = 1'h1;
		wp_in = 1'h0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'h0;
		repeat (5) @(posedge clock);
		t_wrap_write;
		t_random_read;
		t_current_read;
		t_abort;
		t_mismatch;
		t_protect;
		final_report;
	end
endmodule // serial_fram_two_wire_slave_tb
